// ==== i2c_bus_transfer_sequencer.sv ====
// master-side word sequencer of a two-wire serial bus, reached over APB
// assumes open-drain pads outside; oe low pulls the line low, lines pulled up externally
// Contract
// - init write leaves device slave receiver
// - one write with bus free issues start
// - wait one low time before first fall
// - ninth falling edge raises irq, clears pending
// - scl held low while pending low
// - direction updated on acknowledged address only
// - buffer write resumes transmit, irq at end
// - buffer read resumes receive, acknowledges low
// - buffer read after address is undefined
// - no acknowledge clock when handshake off
// - 1-bit word leaves sda high as nack
// - start detected sets busy, stop clears
// - stop command while busy ends transfer
// - sda captured at every scl rising edge
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_seq_cfg.svh"
module i2c_bus_transfer_sequencer import i2c_seq_pkg::*; #(
   parameter logic [15:0] TLOW_BASE_CYC = 16'(`I2C_TLOW_BASE_CYC)
) (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_n_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   output logic             transfer_irq_o
);
   seq_state_t  state_reg;
   logic [2:0]  rate_reg;
   logic        hshake_reg;
   logic [2:0]  bc_reg;
   logic [6:0]  own_addr_reg;
   logic        free_fmt_reg;
   logic        role_reg;
   logic        dir_reg;
   logic        busy_reg;
   logic        pin_reg;
   logic [1:0]  mode_reg;
   logic [7:0]  sdb_reg;
   logic        lrb_reg;
   logic        stop_req_reg;
   logic        addr_phase_reg;
   logic [3:0]  bit_idx_reg;
   logic [3:0]  word_bits_reg;
   logic [3:0]  data_bits_reg;
   logic [15:0] cnt_reg;
   logic        scl_s;
   logic        sda_s;
   logic        scl_q;
   logic        sda_q;
   logic        access;
   logic        xfer;
   logic        wr_a;
   logic        wr_b;
   logic        wr_d;
   logic        wr_o;
   logic        rd_d;
   logic        start_cmd;
   logic        stop_cmd;
   logic        scl_rise;
   logic        start_det;
   logic        stop_det;
   logic        word_done;
   logic        addr_ack;
   logic        resume;

   function automatic logic [3:0] data_len(input logic [2:0] bc);
      data_len = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
   endfunction : data_len

   function automatic logic [15:0] tlow_cycles(input logic [2:0] rate);
      tlow_cycles = TLOW_BASE_CYC << rate;
   endfunction : tlow_cycles

   i2c_line_sync u_scl_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .line_i    (scl_i),
      .line_o    (scl_s)
   );

   i2c_line_sync u_sda_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .line_i    (sda_i),
      .line_o    (sda_s)
   );

   // bus edges, seen only on synchronised lines
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

   // apb: one wait state so that read data can come from a flop
   assign access = psel_i & penable_i & ~pready_o;
   assign xfer   = psel_i & penable_i & pready_o;
   assign wr_a   = xfer & pwrite_i & (paddr_i == `I2C_OFF_CTRL_A);
   assign wr_b   = xfer & pwrite_i & (paddr_i == `I2C_OFF_CTRL_B);
   assign wr_d   = xfer & pwrite_i & (paddr_i == `I2C_OFF_DATA);
   assign wr_o   = xfer & pwrite_i & (paddr_i == `I2C_OFF_OWN_ADDR);
   assign rd_d   = xfer & ~pwrite_i & (paddr_i == `I2C_OFF_DATA);

   assign start_cmd = wr_b & (pwdata_i[7:4] == 4'hF) & ~busy_reg & (state_reg == ST_IDLE)
                      & (mode_reg == `I2C_MODE_I2C);
   assign stop_cmd  = wr_b & (pwdata_i[7:4] == 4'hD) & busy_reg;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= access;
         pslverr_o <= 1'b0;
         if (access) begin
            prdata_o <= 32'h0000_0000;
            case (paddr_i)
               `I2C_OFF_CTRL_A:   prdata_o[7:0] <= {bc_reg, hshake_reg, 1'b0, rate_reg};
               `I2C_OFF_CTRL_B:   prdata_o[7:0] <= {role_reg, dir_reg, busy_reg, pin_reg, mode_reg, 1'b0, lrb_reg};
               `I2C_OFF_DATA:     prdata_o[7:0] <= sdb_reg;
               `I2C_OFF_OWN_ADDR: prdata_o[7:0] <= {own_addr_reg, free_fmt_reg};
               default:           pslverr_o <= 1'b1;
            endcase
         end
      end
   end

   // configuration written by software
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rate_reg     <= `I2C_RST_RATE;
         hshake_reg   <= 1'b0;
         bc_reg       <= `I2C_RST_BC;
         own_addr_reg <= 7'h00;
         free_fmt_reg <= 1'b0;
         mode_reg     <= `I2C_RST_MODE;
      end else begin
         if (wr_a) begin
            rate_reg   <= pwdata_i[`I2C_A_RATE_LSB +: 3];
            hshake_reg <= pwdata_i[`I2C_A_HSHAKE_BIT];
            bc_reg     <= pwdata_i[`I2C_A_BC_LSB +: 3];
         end
         if (wr_o) begin
            own_addr_reg <= pwdata_i[7:1];
            free_fmt_reg <= pwdata_i[0];
         end
         // command code bits 7:4 also load role and dir; reads there return role, dir, busy and pin
         if (wr_b) begin
            mode_reg <= pwdata_i[`I2C_B_MODE_LSB +: 2];
         end
      end
   end

   // role, direction, bus state and service-pending flag
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         role_reg <= 1'b0;
         dir_reg  <= 1'b0;
         busy_reg <= 1'b0;
         pin_reg  <= 1'b1;
      end else begin
         if (start_det) begin
            busy_reg <= 1'b1;
         end else if (stop_det) begin
            busy_reg <= 1'b0;
         end
         if (stop_det) begin
            role_reg <= 1'b0;
            dir_reg  <= 1'b0;
         end else if (wr_b) begin
            role_reg <= pwdata_i[`I2C_B_ROLE_BIT];
            dir_reg  <= pwdata_i[`I2C_B_DIR_BIT];
         end else if (addr_ack) begin
            dir_reg <= ~sdb_reg[0];
         end
         // software set wins over the end-of-word clear
         if (word_done) begin
            pin_reg <= 1'b0;
         end
         if (wr_d || rd_d || (wr_b && pwdata_i[`I2C_B_PIN_BIT])) begin
            pin_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lrb_reg <= 1'b0;
      end else if (scl_rise) begin
         lrb_reg <= sda_s;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stop_req_reg <= 1'b0;
      end else if (stop_cmd) begin
         stop_req_reg <= 1'b1;
      end else if (state_reg == ST_STOP_LOW) begin
         stop_req_reg <= 1'b0;
      end
   end

   // the buffer shifts the bus level back in, so a transmitter reads back what it sent
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sdb_reg <= 8'h00;
      end else if (wr_d) begin
         sdb_reg <= pwdata_i[7:0];
      end else if (state_reg == ST_BIT_HIGH && scl_rise && bit_idx_reg < data_bits_reg) begin
         sdb_reg <= {sdb_reg[6:0], sda_s};
      end
   end

   assign word_done = (state_reg == ST_BIT_HIGH) && scl_s && (cnt_reg == 16'h0000)
                      && (bit_idx_reg == word_bits_reg - 4'h1);
   assign addr_ack  = word_done & addr_phase_reg & ~lrb_reg;
   assign resume    = (state_reg == ST_WAIT_PIN) & pin_reg & ~stop_req_reg;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         transfer_irq_o <= 1'b0;
      end else begin
         transfer_irq_o <= word_done;
      end
   end

   // word length is latched when a word starts, so later writes cannot cut one short
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_bits_reg  <= 4'h8;
         word_bits_reg  <= 4'h9;
         addr_phase_reg <= 1'b0;
      end else if ((state_reg == ST_START) || resume) begin
         data_bits_reg  <= data_len(bc_reg);
         word_bits_reg  <= data_len(bc_reg) + {3'h0, hshake_reg};
         addr_phase_reg <= (state_reg == ST_START);
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 16'h0000;
         bit_idx_reg <= 4'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start_cmd) begin
                  state_reg <= ST_START;
                  cnt_reg   <= tlow_cycles(rate_reg);
               end
            end
            ST_START: begin
               if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else begin
                  state_reg   <= ST_BIT_LOW;
                  cnt_reg     <= tlow_cycles(rate_reg);
                  bit_idx_reg <= 4'h0;
               end
            end
            ST_BIT_LOW: begin
               if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else begin
                  state_reg <= ST_BIT_HIGH;
                  cnt_reg   <= tlow_cycles(rate_reg);
               end
            end
            ST_BIT_HIGH: begin
               // a slave stretching scl keeps reloading the count until the line rises
               if (!scl_s) begin
                  cnt_reg <= tlow_cycles(rate_reg);
               end else if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else if (word_done) begin
                  state_reg <= ST_WAIT_PIN;
               end else begin
                  state_reg   <= ST_BIT_LOW;
                  cnt_reg     <= tlow_cycles(rate_reg);
                  bit_idx_reg <= bit_idx_reg + 4'h1;
               end
            end
            ST_WAIT_PIN: begin
               if (pin_reg && stop_req_reg) begin
                  state_reg <= ST_STOP_LOW;
                  cnt_reg   <= tlow_cycles(rate_reg);
               end else if (resume) begin
                  state_reg   <= ST_BIT_LOW;
                  cnt_reg     <= tlow_cycles(rate_reg);
                  bit_idx_reg <= 4'h0;
               end
            end
            ST_STOP_LOW: begin
               if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else begin
                  state_reg <= ST_STOP_HIGH;
                  cnt_reg   <= tlow_cycles(rate_reg);
               end
            end
            ST_STOP_HIGH: begin
               if (!scl_s) begin
                  cnt_reg <= tlow_cycles(rate_reg);
               end else if (cnt_reg != 16'h0000) begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end else begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // pad drive; a low oe pulls the line low
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_o      <= 1'b0;
         scl_oe_n_o <= 1'b1;
      end else begin
         scl_o <= 1'b0;
         case (state_reg)
            ST_BIT_LOW, ST_WAIT_PIN, ST_STOP_LOW: scl_oe_n_o <= 1'b0;
            ST_BIT_HIGH:                          scl_oe_n_o <= word_done ? 1'b0 : ~(scl_s && cnt_reg == 16'h0000);
            ST_START:                             scl_oe_n_o <= (cnt_reg != 16'h0000);
            default:                              scl_oe_n_o <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sda_o      <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end else begin
         sda_o <= 1'b0;
         case (state_reg)
            ST_START, ST_STOP_LOW: sda_oe_n_o <= 1'b0;
            // sda stays low until scl has stood high a full count, so no false start slips in
            ST_STOP_HIGH:          sda_oe_n_o <= scl_s && (cnt_reg == 16'h0000);
            ST_BIT_LOW: begin
               if (bit_idx_reg < data_bits_reg) begin
                  sda_oe_n_o <= ~((addr_phase_reg || dir_reg) && !sdb_reg[7]);
               end else begin
                  // receiver acknowledges low; a 1-bit word with no handshake stays high
                  sda_oe_n_o <= ~(!addr_phase_reg && !dir_reg);
               end
            end
            ST_WAIT_PIN:           sda_oe_n_o <= ~(pin_reg && stop_req_reg);
            ST_BIT_HIGH:           sda_oe_n_o <= word_done ? 1'b1 : sda_oe_n_o;
            default:               sda_oe_n_o <= 1'b1;
         endcase
      end
   end
endmodule : i2c_bus_transfer_sequencer
`default_nettype wire

// ==== i2c_seq_cfg.svh ====
// register offsets, field positions, reset values and timing counts of the bus sequencer
// assumes a 250 MHz ref_clk_i and APB with 32-bit data, byte addressed
`ifndef I2C_SEQ_CFG_SVH
`define I2C_SEQ_CFG_SVH

`define I2C_OFF_CTRL_A     8'h00
`define I2C_OFF_CTRL_B     8'h04
`define I2C_OFF_DATA       8'h08
`define I2C_OFF_OWN_ADDR   8'h0C

`define I2C_A_RATE_LSB     0
`define I2C_A_HSHAKE_BIT   4
`define I2C_A_BC_LSB       5
`define I2C_B_ROLE_BIT     7
`define I2C_B_DIR_BIT      6
`define I2C_B_BUSY_BIT     5
`define I2C_B_PIN_BIT      4
`define I2C_B_MODE_LSB     2
`define I2C_B_LRB_BIT      0

`define I2C_RST_RATE       3'h0
`define I2C_RST_BC         3'h0
`define I2C_RST_MODE       2'h0
`define I2C_MODE_I2C       2'h2
`define I2C_BC_ONE         3'h1

`define I2C_CLK_PERIOD_NS  4
`define I2C_TLOW_BASE_NS   500
`define I2C_TLOW_BASE_CYC  ((`I2C_TLOW_BASE_NS + `I2C_CLK_PERIOD_NS - 1) / `I2C_CLK_PERIOD_NS)

`endif

// ==== i2c_seq_pkg.sv ====
// types shared by the bus sequencer files
// assumes nothing beyond a SystemVerilog compiler
package i2c_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_BIT_LOW,
      ST_BIT_HIGH,
      ST_WAIT_PIN,
      ST_STOP_LOW,
      ST_STOP_HIGH
   } seq_state_t;
endpackage : i2c_seq_pkg

// ==== i2c_line_sync.sv ====
// two-flop synchroniser for one bus line
// assumes the line idles high, as an open-drain bus does
`timescale 1ns/10ps
`default_nettype none
module i2c_line_sync (
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   input  wire logic line_i,
   output logic      line_o
);
   logic meta_reg;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_reg <= 1'b1;
         line_o   <= 1'b1;
      end else begin
         meta_reg <= line_i;
         line_o   <= meta_reg;
      end
   end
endmodule : i2c_line_sync
`default_nettype wire

// ==== i2c_seq_sva.sv ====
// port checker for the bus sequencer: start timing, clock hold and irq shape
// assumes one clock domain; bound onto every sequencer instance below
`timescale 1ns/10ps
`default_nettype none
module i2c_seq_sva #(
   parameter logic [15:0] TLOW_BASE_CYC = 16'h007d
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic scl_oe_n_o,
   input wire logic sda_oe_n_o,
   input wire logic transfer_irq_o
);
   logic [15:0] hi_cnt;
   // cycles scl has been released, saturating so a long idle never wraps
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) hi_cnt <= 16'h0000;
      else if (!scl_oe_n_o) hi_cnt <= 16'h0000;
      else if (hi_cnt != 16'hffff) hi_cnt <= hi_cnt + 16'h0001;
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);
   sequence s_start;
      scl_oe_n_o && $fell(sda_oe_n_o);
   endsequence
   sequence s_stop;
      scl_oe_n_o && $rose(sda_oe_n_o);
   endsequence
   a_reset_idle: assert property ($rose(resetn_i) |-> scl_oe_n_o && sda_oe_n_o && !transfer_irq_o)
      else $error("bus lines or irq active at reset release");
   a_start_first: assert property (s_start |=> scl_oe_n_o [*3])
      else $error("scl pulled low too soon after start");
   a_start_wait: assert property ($fell(scl_oe_n_o) |-> hi_cnt >= TLOW_BASE_CYC - 16'h0001)
      else $error("scl released for less than one low time");
   a_irq_scl_low: assert property (transfer_irq_o |-> !scl_oe_n_o && $past(scl_oe_n_o))
      else $error("irq not at the falling scl edge");
   a_hold_after_irq: assert property (transfer_irq_o |=> (!scl_oe_n_o) [*3])
      else $error("scl released right after irq");
   a_irq_single: assert property (transfer_irq_o |=> !transfer_irq_o)
      else $error("irq longer than one cycle");
   a_stop_order: assert property (s_stop |-> $past(scl_oe_n_o, 3))
      else $error("sda released before scl stood high");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
endmodule : i2c_seq_sva
bind i2c_bus_transfer_sequencer i2c_seq_sva #(.TLOW_BASE_CYC(TLOW_BASE_CYC)) i2c_seq_sva_inst (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o), .transfer_irq_o(transfer_irq_o)
);
`default_nettype wire

// ==== i2c_slave_model.sv ====
// behavioural bus slave: acks its address and written bytes, returns tx_byte_i on reads
// assumes pulled-up lines resolved by the bench; it never stretches scl
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [7:0] tx_byte_i,
   output logic            sda_oe_n_o,
   output logic      [7:0] rx_byte_o,
   output logic            m_ack_o
);
   logic [7:0] sh;
   logic [3:0] cnt;
   logic       act;
   logic       first;
   logic       rd;
   initial begin
      sda_oe_n_o = 1'b1;
      act = 1'b0;
      rd = 1'b0;
      m_ack_o = 1'b0;
   end
   always @(negedge sda_i) if (scl_i === 1'b1) begin
      act = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      // the start's own scl fall wraps this to zero before the first bit
      cnt = 4'hf;
   end
   always @(posedge sda_i) if (scl_i === 1'b1) act = 1'b0;
   always @(posedge scl_i) if (act) begin
      if (cnt < 4'h8) sh = {sh[6:0], sda_i};
      else if (rd) begin
         m_ack_o = sda_i;
         // a missing acknowledge ends the read so the stop can pass
         rd = rd & ~sda_i;
      end
   end
   always @(negedge scl_i) if (act) begin
      if (cnt == 4'h8) begin
         cnt = 4'h0;
         first = 1'b0;
      end else cnt = cnt + 4'h1;
      if (cnt == 4'h8) begin
         rx_byte_o = sh;
         if (first) rd = sh[0] && (sh[7:1] == ADDR);
         sda_oe_n_o = first ? (sh[7:1] != ADDR) : rd;
      end else sda_oe_n_o = rd ? tx_byte_i[3'(4'h7 - cnt)] : 1'b1;
   end
endmodule : i2c_slave_model
`default_nettype wire

// ==== tb_i2c_bus_transfer_sequencer.sv ====
// self-checking bench: APB software sequences against a behavioural slave
// assumes the sequencer, its checker and the slave model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_bus_transfer_sequencer;
   localparam logic [6:0] SLV_ADDR = 7'h2a;
   logic ref_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, transfer_irq_o;
   logic scl_oe_n_o, sda_oe_n_o, slv_oe_n, m_ack, scl_w, sda_w, scl_o, sda_o;
   logic [7:0] paddr_i, tx_byte, wdat, rx_byte, rises, r;
   logic [31:0] pwdata_i, prdata_o;
   logic [2:0] rate;
   logic [16:0] e;
   logic [16:0] q_exp [$];
   int failures, samples_checked;
   assign scl_w = scl_oe_n_o;
   assign sda_w = sda_oe_n_o & slv_oe_n;
   i2c_bus_transfer_sequencer #(.TLOW_BASE_CYC(16'h000a)) i2c_bus_transfer_sequencer_inst (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .transfer_irq_o(transfer_irq_o));
   i2c_slave_model #(.ADDR(SLV_ADDR)) i2c_slave_model_inst (.scl_i(scl_w), .sda_i(sda_w),
      .tx_byte_i(tx_byte), .sda_oe_n_o(slv_oe_n), .rx_byte_o(rx_byte), .m_ack_o(m_ack));
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge scl_w) rises = rises + 8'h01;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   always @(posedge ref_clk_i) if (pready_o === 1'b1 && q_exp.size() > 0) begin
      e = q_exp.pop_front();
      check({7'h00, pslverr_o, prdata_o[7:0] & e[15:8]}, {7'h00, e[16], e[7:0] & e[15:8]});
   end
   // d is write data or, for reads, the expected value under mask m
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m,
                      output logic [7:0] rv);
      @(posedge ref_clk_i);
      q_exp.push_back({a > 8'h0c, m, d});
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h00_0000, d};
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      // no wait count assumed; only the watchdog ends a hung access
      do begin
         @(posedge ref_clk_i);
      end while (pready_o !== 1'b1);
      rv = prdata_o[7:0];
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wait_irq(input logic [7:0] n);
      while (transfer_irq_o !== 1'b1) begin
         @(posedge ref_clk_i);
      end
      check({8'h00, rises}, {8'h00, n});
      rises = 8'h00;
   endtask : wait_irq
   task automatic start(input logic [7:0] b);
      apb(1'b1, 8'h08, b, 8'h00, r);
      rises = 8'h00;
      apb(1'b1, 8'h04, 8'hf8, 8'h00, r);
      wait_irq(8'h09);
   endtask : start
   task automatic stop_bus;
      int k;
      apb(1'b1, 8'h04, 8'hd8, 8'h00, r);
      k = 0;
      r = 8'hff;
      while (r[5] !== 1'b0 && k < 100) begin
         apb(1'b0, 8'h04, 8'h00, 8'h00, r);
         k++;
      end
      apb(1'b0, 8'h04, 8'h00, 8'h20, r);
      rises = 8'h00;
   endtask : stop_bus
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      failures++;
      give_verdict();
   end
   initial begin
      resetn_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0000_0000;
      rises = 8'h00;
      void'($urandom(32'h0c53_3c9a));
      tx_byte = 8'($urandom());
      wdat = 8'($urandom());
      rate = 3'($urandom_range(1, 0));
      repeat (8) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      apb(1'b0, 8'h00, 8'h00, 8'hff, r);
      apb(1'b0, 8'h04, 8'h10, 8'hfd, r);
      apb(1'b0, 8'h10, 8'h00, 8'hff, r);
      apb(1'b1, 8'h10, 8'h5a, 8'h00, r);
      apb(1'b1, 8'h00, 8'h10 | {5'h00, rate}, 8'h00, r);
      apb(1'b1, 8'h0c, 8'haa, 8'h00, r);
      apb(1'b0, 8'h0c, 8'haa, 8'hff, r);
      apb(1'b1, 8'h04, 8'h18, 8'h00, r);
      apb(1'b0, 8'h04, 8'h18, 8'hfd, r);
      start({SLV_ADDR, 1'b0});
      apb(1'b0, 8'h04, 8'he8, 8'hfd, r);
      apb(1'b1, 8'h08, wdat, 8'h00, r);
      wait_irq(8'h09);
      check({8'h00, rx_byte}, {8'h00, wdat});
      stop_bus();
      start({SLV_ADDR ^ 7'h01, 1'b1});
      apb(1'b0, 8'h04, 8'he9, 8'hfd, r);
      stop_bus();
      start({SLV_ADDR, 1'b1});
      apb(1'b0, 8'h04, 8'ha8, 8'hfd, r);
      apb(1'b0, 8'h08, 8'h00, 8'h00, r);
      wait_irq(8'h09);
      check({15'h0000, m_ack}, 16'h0000);
      apb(1'b1, 8'h00, {5'h00, rate}, 8'h00, r);
      apb(1'b0, 8'h08, tx_byte, 8'hff, r);
      wait_irq(8'h08);
      apb(1'b1, 8'h00, 8'h20 | {5'h00, rate}, 8'h00, r);
      apb(1'b0, 8'h08, tx_byte, 8'hff, r);
      wait_irq(8'h01);
      check({15'h0000, m_ack}, 16'h0001);
      check({14'h0000, scl_o, sda_o}, 16'h0000);
      stop_bus();
      give_verdict();
   end
endmodule : tb_i2c_bus_transfer_sequencer
`default_nettype wire
